// [rtl/sair_regs.svh]
`ifndef SAIR_REGS_SVH
`define SAIR_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SAIR_CLK_PERIOD_NS 5
`define SAIR_BCLK_PERIOD_NS 80
`define SAIR_BCLK_HALF_CYC (`SAIR_BCLK_PERIOD_NS / (2 * `SAIR_CLK_PERIOD_NS))

// ****************************************************************
// Frame layout
// ****************************************************************
`define SAIR_SLOTS_PER_FRAME 64
`define SAIR_SLOTS_PER_HALF 6'h20
`define SAIR_MAX_BITS 6'h18
`define SAIR_IDX_MAX 6'h3F
`define SAIR_DSP_PULSE_IDX 5'h1F
`define SAIR_RESYNC_SLOT 6'h3E
`define SAIR_FIFO_DEPTH 16

// ****************************************************************
// Word length field, bits 1:0
// ****************************************************************
`define SAIR_WLEN_LSB 0
`define SAIR_WLEN_24 2'h0
`define SAIR_WLEN_20 2'h1
`define SAIR_WLEN_16 2'h2
`define SAIR_WLEN_RESET `SAIR_WLEN_24
`define SAIR_DSP_LEFT_RESET 1'h1

`endif

// [rtl/sair_pkg.sv]
`include "sair_regs.svh"

package sair_pkg;

  typedef enum logic [1:0] {
    SAIR_MODE_LJ,
    SAIR_MODE_I2S,
    SAIR_MODE_RJ,
    SAIR_MODE_DSP
  } sair_mode_t;

  typedef logic [23:0] sair_word_t;

  // Unused code 3 falls back to the longest word
  function automatic logic [5:0] sair_wlen_bits(input logic [1:0] code);
    logic [5:0] bits;
    bits = 6'h18;
    if (code == `SAIR_WLEN_20) begin
      bits = 6'h14;
    end else if (code == `SAIR_WLEN_16) begin
      bits = 6'h10;
    end
    return bits;
  endfunction

  // Bits ahead of the first data bit within one channel half
  function automatic logic [5:0] sair_lead(input sair_mode_t mode,
                                           input logic [1:0] code);
    logic [5:0] lead;
    lead = 6'h00;
    if (mode == SAIR_MODE_I2S) begin
      lead = 6'h01;
    end else if (mode == SAIR_MODE_RJ) begin
      lead = `SAIR_SLOTS_PER_HALF - sair_wlen_bits(code);
    end
    return lead;
  endfunction

  function automatic logic [5:0] sair_limit(input sair_mode_t mode,
                                            input logic [1:0] code);
    logic [5:0] lim;
    lim = `SAIR_MAX_BITS;
    if (mode == SAIR_MODE_RJ) begin
      lim = sair_wlen_bits(code);
    end
    return lim;
  endfunction

endpackage

// [rtl/sair_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface sair_if;
  logic bclk;
  logic lrclk;
  logic sdata;

  modport src (
    output bclk,
    output lrclk,
    output sdata
  );

  modport dst (
    input bclk,
    input lrclk,
    input sdata
  );
endinterface

`default_nettype wire

// [rtl/sair_tx.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sair_regs.svh"

module sair_tx
  import sair_pkg::*;
#(
  parameter int BCLK_HALF = `SAIR_BCLK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  sair_if.src link,
  input wire sair_mode_t mode_sel,
  input wire logic [1:0] wlen_sel,
  input wire sair_word_t in_left,
  input wire sair_word_t in_right,
  input wire logic in_valid,
  output logic in_ready
);

  // ****************************************************************
  // Bit clock divider and slot counter
  // ****************************************************************
  logic [7:0] div, next_div;
  logic bclk, next_bclk;
  logic [5:0] slot, next_slot;
  logic lr, next_lr;
  logic sd, next_sd;
  sair_word_t cur_l, cur_r, next_cur_l, next_cur_r;
  sair_word_t stage_l, stage_r, next_stage_l, next_stage_r;
  logic stage_full, next_stage_full;
  sair_mode_t mode_q, next_mode_q;
  logic next_in_ready;
  logic tick, drive, half;
  logic [4:0] idx;
  logic [5:0] lead, lim, pos;
  sair_word_t word;

  always_comb begin
    tick = (div == 8'(BCLK_HALF - 1));
    next_div = tick ? 8'h00 : div + 8'h01;
    next_bclk = tick ? !bclk : bclk;
    // DSP data moves on the rising edge so the far end samples it falling
    drive = tick && ((mode_sel == SAIR_MODE_DSP) ? !bclk : bclk);
    next_slot = drive ? slot + 6'h01 : slot;
    next_mode_q = mode_sel;
    // A format switch restarts the frame so the DSP pulse leads the left word
    if (mode_sel != mode_q) begin
      next_slot = `SAIR_RESYNC_SLOT;
    end
    next_cur_l = cur_l;
    next_cur_r = cur_r;
    next_stage_l = stage_l;
    next_stage_r = stage_r;
    next_stage_full = stage_full;
    if (drive && next_slot == 6'h00) begin
      // An empty stage sends silence rather than stalling the link
      next_cur_l = stage_full ? stage_l : '0;
      next_cur_r = stage_full ? stage_r : '0;
      next_stage_full = 1'b0;
    end
    if (in_valid && !stage_full) begin
      next_stage_l = in_left;
      next_stage_r = in_right;
      next_stage_full = 1'b1;
    end
    next_in_ready = !next_stage_full;
    half = next_slot[5];
    idx = next_slot[4:0];
    lead = sair_lead(mode_sel, wlen_sel);
    lim = sair_limit(mode_sel, wlen_sel);
    pos = {1'b0, idx} - lead;
    word = half ? next_cur_r : next_cur_l;
    next_sd = sd;
    next_lr = lr;
    if (drive) begin
      next_sd = 1'b0;
      if ({1'b0, idx} >= lead && pos < lim) begin
        next_sd = word[5'(6'h17 - pos)];
      end
      unique case (mode_sel)
        SAIR_MODE_LJ, SAIR_MODE_RJ: next_lr = !half;
        SAIR_MODE_I2S: next_lr = half;
        // One pulse per half, left first, at twice the frame rate
        SAIR_MODE_DSP: next_lr = (idx == `SAIR_DSP_PULSE_IDX);
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div <= 8'h00;
      bclk <= 1'b0;
      slot <= `SAIR_IDX_MAX;
      lr <= 1'b0;
      sd <= 1'b0;
      cur_l <= '0;
      cur_r <= '0;
      stage_l <= '0;
      stage_r <= '0;
      stage_full <= 1'b0;
      mode_q <= SAIR_MODE_LJ;
      in_ready <= 1'b1;
    end else begin
      div <= next_div;
      bclk <= next_bclk;
      slot <= next_slot;
      lr <= next_lr;
      sd <= next_sd;
      cur_l <= next_cur_l;
      cur_r <= next_cur_r;
      stage_l <= next_stage_l;
      stage_r <= next_stage_r;
      stage_full <= next_stage_full;
      mode_q <= next_mode_q;
      in_ready <= next_in_ready;
    end
  end

  assign link.bclk = bclk;
  assign link.lrclk = lr;
  assign link.sdata = sd;
endmodule

`default_nettype wire

// [rtl/sair_rx.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sair_regs.svh"

// ****************************************************************
// Frame buffer
// ****************************************************************
module sair_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = `SAIR_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr, rd, next_wr, next_rd;
  logic full, empty, push, pop;

  always_comb begin
    empty = (wr == rd);
    full = (wr[AW] != rd[AW]) && (wr[AW-1:0] == rd[AW-1:0]);
    push = in_valid && !full;
    pop = out_valid && out_ready;
    next_wr = push ? wr + 1'b1 : wr;
    next_rd = pop ? rd + 1'b1 : rd;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr <= '0;
      rd <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr[AW-1:0]] <= in_data;
    end
  end

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd[AW-1:0]];

endmodule

// ****************************************************************
// Deframer
// ****************************************************************
module sair_rx
  import sair_pkg::*;
#(
  parameter int DEPTH = `SAIR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  sair_if.dst link,
  input wire sair_mode_t mode_sel,
  input wire logic [1:0] wlen_sel,
  input wire logic out_ready,
  output sair_word_t out_left,
  output sair_word_t out_right,
  output logic out_valid,
  output logic overrun
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic b1, b2, b3, l1, l2, d1, d2;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      b1 <= 1'b0;
      b2 <= 1'b0;
      b3 <= 1'b0;
      l1 <= 1'b0;
      l2 <= 1'b0;
      d1 <= 1'b0;
      d2 <= 1'b0;
    end else begin
      b1 <= link.bclk;
      b2 <= b1;
      b3 <= b2;
      l1 <= link.lrclk;
      l2 <= l1;
      d1 <= link.sdata;
      d2 <= d1;
    end
  end

  // ****************************************************************
  // Channel tracking and bit capture
  // ****************************************************************
  sair_mode_t mode_q, next_mode_q;
  logic lr_prev, next_lr_prev;
  logic [5:0] idx, next_idx;
  logic active, next_active;
  logic chan_left, next_chan_left;
  logic got_left, next_got_left;
  logic frame_ok, next_frame_ok;
  logic dsp_left, next_dsp_left;
  sair_word_t left_word, right_word, next_left_word, next_right_word;
  logic samp, start, start_left, push, dsp_gap;
  logic [5:0] bit_idx, lead, lim, pos;
  logic fifo_ready, fifo_valid;
  logic [47:0] fifo_data;
  sair_word_t next_out_left, next_out_right;
  logic next_out_valid, next_overrun, pop;

  always_comb begin
    // Edge choice: DSP samples falling, every other format rising
    samp = (mode_sel == SAIR_MODE_DSP) ? (!b2 && b3) : (b2 && !b3);
    start = 1'b0;
    start_left = 1'b0;
    unique case (mode_sel)
      SAIR_MODE_LJ, SAIR_MODE_RJ: begin
        start = (l2 != lr_prev);
        start_left = l2;
      end
      SAIR_MODE_I2S: begin
        start = (l2 != lr_prev);
        start_left = !l2;
      end
      SAIR_MODE_DSP: begin
        // Pulse gives no channel; alternation is counted here
        start = !l2 && lr_prev;
        start_left = dsp_left;
      end
    endcase
    dsp_gap = (mode_sel == SAIR_MODE_DSP) && l2;
    bit_idx = start ? 6'h00 :
              (idx == `SAIR_IDX_MAX) ? idx : idx + 6'h01;
    lead = sair_lead(mode_sel, wlen_sel);
    lim = sair_limit(mode_sel, wlen_sel);
    pos = bit_idx - lead;
    push = 1'b0;
    next_mode_q = mode_sel;
    next_lr_prev = lr_prev;
    next_idx = idx;
    next_active = active;
    next_chan_left = chan_left;
    next_got_left = got_left;
    next_frame_ok = frame_ok;
    next_dsp_left = dsp_left;
    next_left_word = left_word;
    next_right_word = right_word;
    if (mode_sel != mode_q) begin
      // Format switch: drop the partial frame and resync
      next_active = 1'b0;
      next_got_left = 1'b0;
      next_frame_ok = 1'b0;
      next_dsp_left = `SAIR_DSP_LEFT_RESET;
    end else if (samp) begin
      next_lr_prev = l2;
      next_idx = bit_idx;
      if (start) begin
        next_active = 1'b1;
        next_chan_left = start_left;
        if (mode_sel == SAIR_MODE_DSP) begin
          next_dsp_left = !start_left;
        end
        if (start_left) begin
          push = frame_ok;
          next_frame_ok = 1'b0;
          next_got_left = 1'b1;
          next_left_word = '0;
        end else begin
          next_frame_ok = got_left;
          next_got_left = 1'b0;
          next_right_word = '0;
        end
      end
      // Bits past the limit are ignored, not flagged
      if ((start || active) && !dsp_gap && bit_idx >= lead && pos < lim) begin
        if (start ? start_left : chan_left) begin
          next_left_word[5'(6'h17 - pos)] = d2;
        end else begin
          next_right_word[5'(6'h17 - pos)] = d2;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= SAIR_MODE_LJ;
      lr_prev <= 1'b0;
      idx <= `SAIR_IDX_MAX;
      active <= 1'b0;
      chan_left <= 1'b0;
      got_left <= 1'b0;
      frame_ok <= 1'b0;
      dsp_left <= `SAIR_DSP_LEFT_RESET;
      left_word <= '0;
      right_word <= '0;
    end else begin
      mode_q <= next_mode_q;
      lr_prev <= next_lr_prev;
      idx <= next_idx;
      active <= next_active;
      chan_left <= next_chan_left;
      got_left <= next_got_left;
      frame_ok <= next_frame_ok;
      dsp_left <= next_dsp_left;
      left_word <= next_left_word;
      right_word <= next_right_word;
    end
  end

  // ****************************************************************
  // Buffer and output stage
  // ****************************************************************
  // The serial source cannot be stalled, so a full buffer drops the frame
  sair_fifo #(
    .WIDTH(48),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({left_word, right_word}),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  always_comb begin
    pop = fifo_valid && out_ready;
    next_out_valid = pop;
    next_out_left = pop ? fifo_data[47:24] : out_left;
    next_out_right = pop ? fifo_data[23:0] : out_right;
    next_overrun = push && !fifo_ready;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_left <= '0;
      out_right <= '0;
      overrun <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_left <= next_out_left;
      out_right <= next_out_right;
      overrun <= next_overrun;
    end
  end

endmodule

`default_nettype wire

// [testbench/sair_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Link checker
// ****************************************************************
module sair_monitor
  import sair_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bclk,
  input wire logic lrclk,
  input wire logic sdata,
  input wire sair_mode_t mode_sel,
  input wire logic overrun
);
  logic bclk_q;
  logic lrclk_q;
  logic seen;
  logic next_seen;
  logic [6:0] n_frame;
  logic [6:0] n_high;
  logic [6:0] next_n_frame;
  logic [6:0] next_n_high;
  logic b_rise;
  logic l_rise;
  logic dsp;
  sair_mode_t mode_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  assign b_rise = bclk & ~bclk_q;
  assign l_rise = lrclk & ~lrclk_q;
  assign dsp = (mode_sel == SAIR_MODE_DSP);

  // A mode change voids the frame in flight, so wait for a clean start
  always_comb begin
    next_n_frame = n_frame + {6'h00, b_rise};
    next_n_high = n_high + {6'h00, b_rise & lrclk};
    next_seen = seen;
    if (l_rise) begin
      next_n_frame = {6'h00, b_rise};
      next_n_high = {6'h00, b_rise};
      next_seen = 1'h1;
    end
    if (mode_sel != mode_q) begin
      next_seen = 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bclk_q <= 1'h0;
      lrclk_q <= 1'h0;
      seen <= 1'h0;
      n_frame <= 7'h00;
      n_high <= 7'h00;
      mode_q <= SAIR_MODE_LJ;
    end else begin
      bclk_q <= bclk;
      lrclk_q <= lrclk;
      seen <= next_seen;
      n_frame <= next_n_frame;
      n_high <= next_n_high;
      mode_q <= mode_sel;
    end
  end

  a_frame_bclk_count: assert property (
    l_rise && seen |-> n_frame == (dsp ? 7'h20 : 7'h40))
    else $error("Bit clocks per frame wrong");
  a_half_frame_len: assert property (
    seen && !dsp && $fell(lrclk) |-> n_high == 7'h20)
    else $error("Frame clock high half wrong");
  a_dsp_pulse_width: assert property (
    seen && dsp && $rose(lrclk) |-> ##8 lrclk ##8 !lrclk)
    else $error("Frame pulse width wrong");
  a_sdata_fall_edge: assert property (
    seen && !dsp && $changed(sdata) |-> $fell(bclk))
    else $error("Data moved off falling bit clock");
  a_sdata_rise_edge: assert property (
    seen && dsp && $changed(sdata) |-> $rose(bclk))
    else $error("Data moved off rising bit clock");
  a_lrclk_bclk_edge: assert property (
    seen && $changed(lrclk) |-> (dsp ? $rose(bclk) : $fell(bclk)))
    else $error("Frame clock moved on wrong edge");
  a_bclk_half_period: assert property (
    $changed(bclk) |=> $stable(bclk) [*7] ##1 $changed(bclk))
    else $error("Bit clock half period wrong");
  a_overrun_pulse: assert property (
    overrun |=> !overrun)
    else $error("Overrun longer than one cycle");
endmodule

`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sair_regs.svh"

module tb
  import sair_pkg::*;
;
  logic clk;
  logic rst_b;
  sair_mode_t mode_sel;
  logic [1:0] wlen_sel;
  sair_word_t in_left;
  sair_word_t in_right;
  logic in_valid;
  logic in_ready;
  logic out_ready;
  sair_word_t out_left;
  sair_word_t out_right;
  logic out_valid;
  logic overrun;
  int errors;
  int checks;

  sair_if sair_if_i ();
  sair_tx sair_tx_i (.clk(clk), .rst_b(rst_b), .link(sair_if_i),
    .mode_sel(mode_sel), .wlen_sel(wlen_sel), .in_left(in_left),
    .in_right(in_right), .in_valid(in_valid), .in_ready(in_ready));
  sair_rx sair_rx_i (.clk(clk), .rst_b(rst_b), .link(sair_if_i),
    .mode_sel(mode_sel), .wlen_sel(wlen_sel), .out_ready(out_ready),
    .out_left(out_left), .out_right(out_right), .out_valid(out_valid),
    .overrun(overrun));
  sair_monitor sair_monitor_i (.clk(clk), .rst_b(rst_b),
    .bclk(sair_if_i.bclk), .lrclk(sair_if_i.lrclk),
    .sdata(sair_if_i.sdata), .mode_sel(mode_sel), .overrun(overrun));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_word(input sair_word_t got, input sair_word_t exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (out_valid !== 1'h1 && n < 4000);
    if (out_valid !== 1'h1) begin
      errors++;
      $display("Error at %0t: no sample pair", $time);
      print_verdict();
    end
  endtask

  // Left word start edge, then the MSB after lead rising bit clocks
  task automatic check_wire(input logic lvl, input int lead, input logic msb);
    int n;
    int rises;
    logic found;
    logic lq;
    logic bq;
    rises = 0;
    found = 1'h0;
    lq = sair_if_i.lrclk;
    bq = sair_if_i.bclk;
    for (n = 0; n < 4000 && rises <= lead; n++) begin
      @(negedge clk);
      if (found && bq === 1'h0 && sair_if_i.bclk === 1'h1) begin
        if (rises == lead) begin
          check_bit(sair_if_i.sdata, msb);
        end
        rises++;
      end
      if (lq !== lvl && sair_if_i.lrclk === lvl) begin
        found = 1'h1;
      end
      lq = sair_if_i.lrclk;
      bq = sair_if_i.bclk;
    end
    check_bit(rises > lead, 1'h1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // First pairs after a mode change may be stale or dropped; skip them
  task automatic run_mode(input sair_mode_t m, input logic [1:0] w,
      input sair_word_t l, input sair_word_t r, input sair_word_t el,
      input sair_word_t er, input logic lvl, input int lead);
    int k;
    @(posedge clk);
    mode_sel <= m;
    wlen_sel <= w;
    in_left <= l;
    in_right <= r;
    in_valid <= 1'h1;
    for (k = 0; k < 5; k++) begin
      wait_strobe();
      if (k > 2) begin
        check_word(out_left, el);
        check_word(out_right, er);
      end
    end
    if (lead >= 0) begin
      check_wire(lvl, lead, el[23]);
    end
    $display("Test done: mode %0d length code %0d", m, w);
  endtask

  task automatic fill_drain();
    int n;
    int got;
    got = 0;
    @(posedge clk);
    out_ready <= 1'h0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (overrun !== 1'h1 && n < 24000);
    check_bit(overrun, 1'h1);
    @(posedge clk);
    out_ready <= 1'h1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      if (out_valid === 1'h1) begin
        got++;
        check_word(out_left, 24'h812345);
      end
    end
    check_bit(got >= 16 && got <= 17, 1'h1);
    $display("Test done: buffer fill and drain, %0d pairs", got);
  endtask

  initial begin
    errors = 0;
    checks = 0;
    rst_b = 1'h0;
    mode_sel = SAIR_MODE_LJ;
    wlen_sel = 2'h0;
    in_left = 24'h000000;
    in_right = 24'h000000;
    in_valid = 1'h0;
    out_ready = 1'h1;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    run_mode(SAIR_MODE_RJ, `SAIR_WLEN_24, 24'hCCCCCC, 24'h333333,
      24'hCCCCCC, 24'h333333, 1'h1, 8);
    run_mode(SAIR_MODE_I2S, 2'h0, 24'h812345, 24'h7E5A3C,
      24'h812345, 24'h7E5A3C, 1'h0, 1);
    run_mode(SAIR_MODE_RJ, `SAIR_WLEN_20, 24'hCCCCCC, 24'h333333,
      24'hCCCCC0, 24'h333330, 1'h1, 12);
    run_mode(SAIR_MODE_DSP, 2'h0, 24'h812345, 24'h7E5A3C,
      24'h812345, 24'h7E5A3C, 1'h1, -1);
    run_mode(SAIR_MODE_RJ, `SAIR_WLEN_16, 24'hCCCCCC, 24'h333333,
      24'hCCCC00, 24'h333300, 1'h1, 16);
    run_mode(SAIR_MODE_LJ, 2'h0, 24'h812345, 24'h7E5A3C,
      24'h812345, 24'h7E5A3C, 1'h1, 0);
    fill_drain();
    print_verdict();
  end
endmodule

`default_nettype wire
